// File: hdl/afe_defs.svh
`ifndef AFE_DEFS_SVH
`define AFE_DEFS_SVH
// register word offsets
`define AFE_REG_FIFO_STATUS   6'h00
`define AFE_REG_OPT_LEV0      6'h01
`define AFE_REG_OPT_LEV1      6'h02
`define AFE_REG_IMP_SAT       6'h03
`define AFE_REG_CARDIAC_STAT  6'h04
`define AFE_REG_GLOBAL_STAT   6'h05
`define AFE_REG_FIFO_THRESH   6'h06
`define AFE_REG_INT_ACLR      6'h07
`define AFE_REG_PART_ID       6'h08
`define AFE_REG_FOSC_TRIM     6'h09
`define AFE_REG_FOSC_CAL      6'h0a
`define AFE_REG_SOSC_TRIM     6'h0b
`define AFE_REG_SLOT_PER_LO   6'h0d
`define AFE_REG_SLOT_PER_HI   6'h0e
`define AFE_REG_SYS_CTRL      6'h0f
`define AFE_REG_OP_MODE       6'h10
`define AFE_REG_TSTAMP_LO     6'h11
`define AFE_REG_TSTAMP_HI     6'h12
`define AFE_REG_TSTAMP_DELTA  6'h13
`define AFE_REG_IRQ_X_EN      6'h14
`define AFE_REG_IRQ_Y_EN      6'h15
`define AFE_REG_STAT_BYTES    6'h1e
`define AFE_REG_IN_SLEEP      6'h20
`define AFE_REG_IN_PAIR       6'h21
`define AFE_REG_PIN_CFG       6'h22
`define AFE_REG_PIN_OUT       6'h23
`define AFE_REG_PIN_IN        6'h25
`define AFE_REG_PIN_SYNC      6'h26
`define AFE_REG_FIFO_READ     6'h2f
`define AFE_REG_FUSE_CTRL     6'h3f
`define AFE_REG_DC_INJECT     6'h30
// printed fuse offset is 0x044, kept apart since it exceeds 6 bits
`define AFE_REG_FUSE_FULL     7'h44
// reset values
`define AFE_RST_CARDIAC_STAT  16'h00fc
`define AFE_RST_FIFO_THRESH   16'h000c
`define AFE_RST_INT_ACLR      16'h8000
`define AFE_RST_FOSC_TRIM     16'h0080
`define AFE_RST_SOSC_TRIM     16'h0ab2
`define AFE_RST_SLOT_PER_LO   16'h2580
`define AFE_RST_STAT_BYTES    16'h0200
`define AFE_RST_FUSE_CTRL     16'h0005
`define AFE_RST_ZERO          16'h0000
// identity value is arbitrary
`define AFE_PART_ID_VALUE     16'h0042
// dc injection register field positions
`define AFE_DC_POS_EN_BIT     0
`define AFE_DC_NEG_EN_BIT     1
`define AFE_DC_LOW_LSB        2
`define AFE_DC_MID_LSB        6
`define AFE_DC_HIGH_LSB       10
`define AFE_DC_FIELD_W        4
// fifo pattern layout, byte offsets
`define AFE_PAT_BYTES         6'd52
`define AFE_PAT_CARD_END      6'd20
`define AFE_PAT_OPT_END       6'd28
`define AFE_PAT_CARD_BYTES    5'd20
`define AFE_PAT_OPT_BYTES     3'd4
`define AFE_PAT_IMP_BYTES     3'd6
`define AFE_FIFO_DEPTH_LOG2   10
`endif

// File: hdl/afe_pkg.sv
package afe_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } afe_req_t;
  typedef struct packed {
    logic        pos_en;
    logic        neg_en;
    logic [3:0]  low_mag;
    logic [3:0]  mid_mag;
    logic [3:0]  high_mag;
  } afe_dc_cfg_t;
  typedef enum logic [1:0] {
    AFE_SEG_CARD = 2'b00,
    AFE_SEG_OPT  = 2'b01,
    AFE_SEG_IMP  = 2'b11
  } afe_seg_t;
endpackage

// File: hdl/afe_fifo_mem.sv
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_fifo_mem
  import afe_pkg::*;
(
  // clock
  input  wire logic        clock,
  // write side
  input  wire logic        wr_en,
  input  wire logic [9:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  // read side
  input  wire logic [9:0]  rd_addr,
  output logic      [7:0]  rd_data
);
  logic [7:0] mem [0:(1<<`AFE_FIFO_DEPTH_LOG2)-1];
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule // afe_fifo_mem

// File: hdl/afe_top_control.sv
// Operation
// - dc current magnitude comes from low, mid and high magnitude fields.
// - block works straight out of reset with no power-up ordering.
// - each multimodal pattern written to the fifo is exactly 52 bytes.
// - bytes 0-19 cardiac, 20-27 two optical, 28-51 four impedance results.
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_top_control
  import afe_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire afe_req_t    req,
  output logic      [15:0] rdata_q,
  output logic             rvalid_q,
  // measurement byte stream
  input  wire logic        src_valid,
  input  wire logic [7:0]  src_byte,
  input  wire afe_seg_t    src_seg,
  // external pin inputs
  input  wire logic [2:0]  pin_in,
  // dc injection drive
  output afe_dc_cfg_t      dc_cfg_q,
  output logic             dc_mode_q,
  output logic [13:0]      dc_current_code_q,
  // pattern alignment fault
  output logic             pattern_error_q
);
  logic [15:0] regs_q [0:63];
  logic [15:0] fuse_q;
  logic [15:0] dc_reg_q;
  logic [2:0]  pin_s1_q;
  logic [2:0]  pin_s2_q;
  logic [10:0] count_q;
  logic [9:0]  wptr_q;
  logic [9:0]  rptr_q;
  logic [5:0]  pat_idx_q;
  logic [7:0]  mem_rd;
  logic [7:0]  low_byte_q;
  logic        wr_ok;
  logic        rd_fifo;
  logic [31:0] tstamp_q;
  afe_seg_t    exp_seg;
  logic [5:0]  a6;
  logic        fuse_hit;

  assign a6       = req.addr[5:0];
  assign fuse_hit = (req.addr == `AFE_REG_FUSE_FULL);

  // expected segment for the current byte slot of the pattern
  always_comb begin
    if (pat_idx_q < `AFE_PAT_CARD_END) begin
      exp_seg = AFE_SEG_CARD;
    end else if (pat_idx_q < `AFE_PAT_OPT_END) begin
      exp_seg = AFE_SEG_OPT;
    end else begin
      exp_seg = AFE_SEG_IMP;
    end
  end

  // bytes of the wrong kind are dropped so patterns stay aligned
  assign wr_ok   = src_valid && (src_seg == exp_seg) && (count_q < 11'd1024);
  assign rd_fifo = req.rd && !req.addr[6] && (a6 == `AFE_REG_FIFO_READ) && (count_q != 11'd0);

  // pins from outside the clock domain
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // pattern slot counter wraps every 52 bytes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pat_idx_q       <= 6'd0;
      pattern_error_q <= 1'b0;
    end else if (src_valid) begin
      pattern_error_q <= (src_seg != exp_seg);
      if (wr_ok) begin
        if (pat_idx_q == `AFE_PAT_BYTES - 6'd1) begin
          pat_idx_q <= 6'd0;
        end else begin
          pat_idx_q <= pat_idx_q + 6'd1;
        end
      end
    end else begin
      pattern_error_q <= 1'b0;
    end
  end

  // fifo pointers and byte count; each read of the fifo register while it holds data consumes one byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q  <= 10'd0;
      rptr_q  <= 10'd0;
      count_q <= 11'd0;
    end else if (req.wr && !req.addr[6] && a6 == `AFE_REG_FIFO_STATUS && req.wdata[15]) begin
      wptr_q  <= 10'd0;
      rptr_q  <= 10'd0;
      count_q <= 11'd0;
    end else begin
      if (wr_ok) begin
        wptr_q <= wptr_q + 10'd1;
      end
      if (rd_fifo) begin
        rptr_q <= rptr_q + 10'd1;
      end
      count_q <= count_q + {10'd0, wr_ok} - {10'd0, rd_fifo};
    end
  end

  afe_fifo_mem u_mem (
    .clock   (clock),
    .wr_en   (wr_ok),
    .wr_addr (wptr_q),
    .wr_data (src_byte),
    .rd_addr (rptr_q),
    .rd_data (mem_rd)
  );

  // free-running timestamp
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tstamp_q <= 32'h0000_0000;
    end else begin
      tstamp_q <= tstamp_q + 32'h0000_0001;
    end
  end

  // writable registers; read-only offsets never take writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= `AFE_RST_ZERO;
      end
      regs_q[`AFE_REG_CARDIAC_STAT] <= `AFE_RST_CARDIAC_STAT;
      regs_q[`AFE_REG_FIFO_THRESH]  <= `AFE_RST_FIFO_THRESH;
      regs_q[`AFE_REG_INT_ACLR]     <= `AFE_RST_INT_ACLR;
      regs_q[`AFE_REG_FOSC_TRIM]    <= `AFE_RST_FOSC_TRIM;
      regs_q[`AFE_REG_SOSC_TRIM]    <= `AFE_RST_SOSC_TRIM;
      regs_q[`AFE_REG_SLOT_PER_LO]  <= `AFE_RST_SLOT_PER_LO;
      regs_q[`AFE_REG_STAT_BYTES]   <= `AFE_RST_STAT_BYTES;
    end else if (req.wr && !req.addr[6]) begin
      unique case (a6)
        `AFE_REG_PART_ID, `AFE_REG_TSTAMP_LO, `AFE_REG_TSTAMP_HI,
        `AFE_REG_TSTAMP_DELTA, `AFE_REG_PIN_IN, `AFE_REG_FIFO_READ,
        `AFE_REG_FIFO_STATUS: begin
          regs_q[a6] <= regs_q[a6];
        end
        default: begin
          regs_q[a6] <= req.wdata;
        end
      endcase
    end
  end

  // fuse control sits above the 6-bit window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fuse_q <= `AFE_RST_FUSE_CTRL;
    end else if (req.wr && fuse_hit) begin
      fuse_q <= req.wdata;
    end
  end

  // dc injection control word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dc_reg_q <= `AFE_RST_ZERO;
    end else if (req.wr && !req.addr[6] && a6 == `AFE_REG_DC_INJECT) begin
      dc_reg_q <= req.wdata;
    end
  end

  // dc current drive: mode needs both enables, magnitude from three fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dc_cfg_q          <= '0;
      dc_mode_q         <= 1'b0;
      dc_current_code_q <= 14'd0;
    end else begin
      dc_cfg_q.pos_en   <= dc_reg_q[`AFE_DC_POS_EN_BIT];
      dc_cfg_q.neg_en   <= dc_reg_q[`AFE_DC_NEG_EN_BIT];
      dc_cfg_q.low_mag  <= dc_reg_q[`AFE_DC_LOW_LSB +: `AFE_DC_FIELD_W];
      dc_cfg_q.mid_mag  <= dc_reg_q[`AFE_DC_MID_LSB +: `AFE_DC_FIELD_W];
      dc_cfg_q.high_mag <= dc_reg_q[`AFE_DC_HIGH_LSB +: `AFE_DC_FIELD_W];
      dc_mode_q <= dc_reg_q[`AFE_DC_POS_EN_BIT] & dc_reg_q[`AFE_DC_NEG_EN_BIT];
      // low field weighs 64, mid 8, high 1; analog side maps the code to current
      dc_current_code_q <= {4'd0, dc_reg_q[`AFE_DC_LOW_LSB +: `AFE_DC_FIELD_W], 6'd0}
                           + {7'd0, dc_reg_q[`AFE_DC_MID_LSB +: `AFE_DC_FIELD_W], 3'd0}
                           + {10'd0, dc_reg_q[`AFE_DC_HIGH_LSB +: `AFE_DC_FIELD_W]};
    end
  end

  // read mux; fifo data pairs two bytes, the byte this read consumes in the high half, previously read byte in the low half
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q    <= `AFE_RST_ZERO;
      rvalid_q   <= 1'b0;
      low_byte_q <= 8'h00;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        if (fuse_hit) begin
          rdata_q <= fuse_q;
        end else if (req.addr[6]) begin
          rdata_q <= `AFE_RST_ZERO;
        end else begin
          unique case (a6)
            `AFE_REG_FIFO_STATUS:  rdata_q <= {5'd0, count_q};
            `AFE_REG_PART_ID:      rdata_q <= `AFE_PART_ID_VALUE;
            `AFE_REG_TSTAMP_LO:    rdata_q <= tstamp_q[15:0];
            `AFE_REG_TSTAMP_HI:    rdata_q <= tstamp_q[31:16];
            `AFE_REG_PIN_IN:       rdata_q <= {13'd0, pin_s2_q};
            `AFE_REG_DC_INJECT:    rdata_q <= dc_reg_q;
            `AFE_REG_FIFO_READ:    rdata_q <= {mem_rd, low_byte_q};
            default:               rdata_q <= regs_q[a6];
          endcase
        end
      end
      if (rd_fifo) begin
        low_byte_q <= mem_rd;
      end
    end
  end
endmodule // afe_top_control

// File: test/afe_top_control_checker.sv
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_top_control_checker
  import afe_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register port
  input wire afe_req_t    req,
  input wire logic [15:0] rdata_q,
  input wire logic        rvalid_q,
  // byte stream
  input wire logic        src_valid,
  input wire afe_seg_t    src_seg,
  // dc injection and fault
  input wire afe_dc_cfg_t dc_cfg_q,
  input wire logic        dc_mode_q,
  input wire logic [13:0] dc_current_code_q,
  input wire logic        pattern_error_q
);
  logic [5:0] slot_q;
  afe_seg_t   exp_seg;
  assign exp_seg = (slot_q < 6'd20) ? AFE_SEG_CARD :
                   (slot_q < 6'd28) ? AFE_SEG_OPT : AFE_SEG_IMP;
  // a dropped byte must not advance the slot, so only matches count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) slot_q <= 6'd0;
    else if (src_valid && src_seg == exp_seg) slot_q <= (slot_q == 6'd51) ? 6'd0 : slot_q + 6'd1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_read_answer: assert property (req.rd |=> rvalid_q)
    else $error("read not answered");
  chk_no_stray: assert property (!req.rd |=> !rvalid_q)
    else $error("stray read valid");
  chk_rdata_hold: assert property (!req.rd |=> $stable(rdata_q))
    else $error("read data moved");
  chk_id_read: assert property (req.rd && req.addr == 7'h08 |=> rdata_q == `AFE_PART_ID_VALUE)
    else $error("identity read wrong");
  chk_dc_mode: assert property (dc_mode_q == (dc_cfg_q.pos_en && dc_cfg_q.neg_en))
    else $error("dc mode wrong");
  chk_dc_code: assert property (dc_current_code_q == ({10'd0, dc_cfg_q.low_mag} << 6)
    + ({10'd0, dc_cfg_q.mid_mag} << 3) + {10'd0, dc_cfg_q.high_mag}) else $error("dc code wrong");
  chk_dc_write: assert property (req.wr && req.addr == 7'h30 |-> ##3
    dc_cfg_q.low_mag == $past(req.wdata[5:2], 3)) else $error("dc field not taken");
  chk_seg_fault: assert property (src_valid && src_seg != exp_seg |=> pattern_error_q)
    else $error("misplaced byte not flagged");
  chk_seg_quiet: assert property (!(src_valid && src_seg != exp_seg) |=> !pattern_error_q)
    else $error("spurious pattern fault");
endmodule // afe_top_control_checker
bind afe_top_control afe_top_control_checker chk (.clock(clock), .rst_n(rst_n), .req(req),
  .rdata_q(rdata_q), .rvalid_q(rvalid_q), .src_valid(src_valid), .src_seg(src_seg),
  .dc_cfg_q(dc_cfg_q), .dc_mode_q(dc_mode_q), .dc_current_code_q(dc_current_code_q),
  .pattern_error_q(pattern_error_q));

// File: test/afe_src_model.sv
`timescale 1ns/1ps
module afe_src_model
  import afe_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // control from the bench
  input  wire logic       go,
  input  wire logic       bad,
  // byte stream
  output logic            src_valid,
  output logic [7:0]      src_byte,
  output afe_seg_t        src_seg
);
  logic [5:0] slot_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_q    <= 6'd0;
      cnt_q     <= 8'h00;
      src_valid <= 1'b0;
      src_byte  <= 8'h00;
      src_seg   <= AFE_SEG_CARD;
    end else if (go) begin
      src_valid <= 1'b1;
      src_byte  <= cnt_q;
      cnt_q     <= cnt_q + 8'h01;
      slot_q    <= (slot_q == 6'd51) ? 6'd0 : slot_q + 6'd1;
      if (slot_q < 6'd20) src_seg <= bad ? AFE_SEG_OPT : AFE_SEG_CARD;
      else if (slot_q < 6'd28) src_seg <= bad ? AFE_SEG_CARD : AFE_SEG_OPT;
      else src_seg <= bad ? AFE_SEG_CARD : AFE_SEG_IMP;
    end else begin
      src_valid <= 1'b0;
      // idle byte flips so a stale value is never mistaken for data
      src_byte  <= ~src_byte;
    end
  end
endmodule // afe_src_model

// File: test/afe_top_control_and_fifo_map_tb.sv
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_top_control_and_fifo_map_tb
  import afe_pkg::*;
;
  logic        clock;
  logic        rst_n;
  afe_req_t    req;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  logic        src_valid;
  logic [7:0]  src_byte;
  afe_seg_t    src_seg;
  logic [2:0]  pin_in;
  afe_dc_cfg_t dc_cfg_q;
  logic        dc_mode_q;
  logic [13:0] dc_current_code_q;
  logic        pattern_error_q;
  logic        go;
  logic        bad;
  logic [15:0] rd_val;
  logic [15:0] t0;
  int          errors;
  int          samples_checked;
  int          err_seen;
  logic [6:0]  ra [12] = '{7'h08, 7'h04, 7'h06, 7'h07, 7'h09, 7'h0b, 7'h0d, 7'h1e, 7'h44,
                           7'h00, 7'h10, 7'h13};
  logic [15:0] rv [12] = '{16'h0042, 16'h00fc, 16'h000c, 16'h8000, 16'h0080, 16'h0ab2,
                           16'h2580, 16'h0200, 16'h0005, 16'h0000, 16'h0000, 16'h0000};
  afe_top_control uut (.clock(clock), .rst_n(rst_n), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .src_valid(src_valid), .src_byte(src_byte), .src_seg(src_seg),
    .pin_in(pin_in), .dc_cfg_q(dc_cfg_q), .dc_mode_q(dc_mode_q),
    .dc_current_code_q(dc_current_code_q), .pattern_error_q(pattern_error_q));
  afe_src_model far (.clock(clock), .rst_n(rst_n), .go(go), .bad(bad),
    .src_valid(src_valid), .src_byte(src_byte), .src_seg(src_seg));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (pattern_error_q === 1'b1) err_seen++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [6:0] a);
    int n;
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    req.rd <= 1'b0;
    n = 0;
    #1;
    while (rvalid_q !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    rd_val = rdata_q;
  endtask
  task automatic print_verdict;
    $display("TB: errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    pin_in = 3'b000;
    go = 1'b0;
    bad = 1'b0;
    errors = 0;
    samples_checked = 0;
    err_seen = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      reg_rd(ra[i]);
      check(rd_val, rv[i]);
    end
    reg_wr(7'h06, 16'h0123);
    reg_rd(7'h06);
    check(rd_val, 16'h0123);
    reg_wr(7'h08, 16'hffff);
    reg_rd(7'h08);
    check(rd_val, `AFE_PART_ID_VALUE);
    reg_wr(7'h13, 16'hffff);
    reg_rd(7'h13);
    check(rd_val, 16'h0000);
    // timestamp counts every cycle; back-to-back reads sample two edges apart
    reg_rd(7'h11);
    t0 = rd_val;
    reg_rd(7'h11);
    check(rd_val - t0, 16'h0002);
    pin_in <= 3'b101;
    repeat (4) @(posedge clock);
    reg_rd(7'h25);
    check(rd_val, 16'h0005);
    // both enables plus low 3, mid 5, high 7
    reg_wr(7'h30, 16'h1d4f);
    repeat (3) @(posedge clock);
    #1;
    check({2'b00, dc_current_code_q}, 16'h00ef);
    check({15'h0000, dc_mode_q}, 16'h0001);
    reg_wr(7'h30, 16'h0001);
    repeat (3) @(posedge clock);
    #1;
    check({15'h0000, dc_mode_q}, 16'h0000);
    @(posedge clock);
    go <= 1'b1;
    repeat (104) @(posedge clock);
    go <= 1'b0;
    repeat (4) @(posedge clock);
    reg_rd(7'h00);
    check({5'h00, rd_val[10:0]}, 16'h0068);
    reg_rd(7'h2f);
    check({8'h00, rd_val[15:8]}, 16'h0000);
    reg_rd(7'h2f);
    check(rd_val, 16'h0100);
    reg_wr(7'h00, 16'h8000);
    reg_rd(7'h00);
    check({5'h00, rd_val[10:0]}, 16'h0000);
    @(posedge clock);
    go <= 1'b1;
    bad <= 1'b1;
    @(posedge clock);
    bad <= 1'b0;
    repeat (9) @(posedge clock);
    go <= 1'b0;
    repeat (4) @(posedge clock);
    check(16'(err_seen), 16'h0001);
    reg_rd(7'h00);
    check({5'h00, rd_val[10:0]}, 16'h0009);
    print_verdict();
  end
endmodule // afe_top_control_and_fifo_map_tb
